// ===== sbcp_config_port.sv
`timescale 1ns/1ps
module sbcp_config_port #(
  parameter logic [23:0] START_ADDR = 24'h00_0000,
  parameter int          DUMMY_BITS = 8
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       cfgResetN,
  input  wire logic       deviceSelect,
  input  wire logic       activeModeSel,
  input  wire logic [1:0] clkRatioSel,
  input  wire logic       useExtClock,
  input  wire logic       externalCfgClockPin,
  input  wire logic       configSerialClockIn,
  output logic            configSerialClockOut,
  output logic            configSerialClockOe,
  input  wire logic       flashSelectNIn,
  output logic            flashSelectNOut,
  output logic            flashSelectNOe,
  input  wire logic       configDataIn,
  output logic            flashCmdOut,
  output logic            flashCmdOe,
  input  wire logic       bitstreamDone,
  output logic [7:0]      cfgByte,
  output logic            cfgByteValid,
  output logic            cfgBusy,
  output logic            cfgDone,
  output logic            cfgAbort
);

  // ---------------------------------------------------------------------------
  // state and helpers
  // ---------------------------------------------------------------------------
  sbcp_pkg::sbcp_state_t state_r, state_nxt;

  logic [5:0]  trigLowCnt_r;
  logic        resetNPrev_r;
  logic        modeActive_r;
  logic        extSrc_r;
  logic [1:0]  ratio_r;
  logic [11:0] waitCnt_r;
  logic [4:0]  bitCnt_r;
  logic [6:0]  tailCnt_r;
  logic [31:0] txShift_r;
  logic [7:0]  rxShift_r;
  logic        extPrev_r;
  logic        sckInPrev_r;
  logic        divTick;
  logic        extEdge;
  logic        edgeTick;
  logic        riseEdge;
  logic        fallEdge;
  logic        pasvRise;
  logic        sampleEdge;
  logic        trigStart;
  logic        abortNow;

  function automatic logic isClocked(input sbcp_pkg::sbcp_state_t s);
    isClocked = (s == sbcp_pkg::ST_WAKE) || (s == sbcp_pkg::ST_CMD) ||
                (s == sbcp_pkg::ST_ADDR) || (s == sbcp_pkg::ST_DUMMY) ||
                (s == sbcp_pkg::ST_STREAM);
  endfunction

  function automatic logic isLast(input logic [4:0] cnt, input int len);
    isLast = (cnt == 5'(len - 1));
  endfunction

  // ---------------------------------------------------------------------------
  // trigger and strap capture
  // ---------------------------------------------------------------------------
  assign trigStart = cfgResetN && !resetNPrev_r &&
                     (trigLowCnt_r == 6'(sbcp_pkg::TRIG_LOW_CYCLES));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      trigLowCnt_r <= 6'h00;
      resetNPrev_r <= 1'b1;
    end else begin
      resetNPrev_r <= cfgResetN;
      if (cfgResetN)
        trigLowCnt_r <= 6'h00;
      else if (trigLowCnt_r != 6'(sbcp_pkg::TRIG_LOW_CYCLES))
        trigLowCnt_r <= trigLowCnt_r + 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      modeActive_r <= 1'b0;
      extSrc_r     <= 1'b0;
      ratio_r      <= sbcp_pkg::CFG_CLK_RATIO_FULL;
    end else if (trigStart) begin
      modeActive_r <= activeModeSel;
      extSrc_r     <= useExtClock;
      ratio_r      <= clkRatioSel;
    end
  end

  // ---------------------------------------------------------------------------
  // serial clock edges
  // ---------------------------------------------------------------------------
  sbcp_clk_div u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (isClocked(state_r) && !extSrc_r),
    .ratioSel (ratio_r),
    .tick     (divTick)
  );

  // external pin is ignored unless selected as the source
  assign extEdge    = externalCfgClockPin != extPrev_r;
  assign edgeTick   = extSrc_r ? extEdge : divTick;
  assign riseEdge   = isClocked(state_r) && edgeTick && !configSerialClockOut;
  assign fallEdge   = isClocked(state_r) && edgeTick && configSerialClockOut;
  assign pasvRise   = !sckInPrev_r && configSerialClockIn && !flashSelectNIn;
  assign sampleEdge = (state_r == sbcp_pkg::ST_PASV || state_r == sbcp_pkg::ST_TAIL) ?
                      pasvRise : riseEdge;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      extPrev_r   <= 1'b0;
      sckInPrev_r <= 1'b1;
    end else begin
      extPrev_r   <= externalCfgClockPin;
      sckInPrev_r <= configSerialClockIn;
    end
  end

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  assign abortNow = cfgResetN && !trigStart && !deviceSelect &&
                    state_r != sbcp_pkg::ST_IDLE && state_r != sbcp_pkg::ST_DONE;

  always_comb begin
    state_nxt = state_r;
    if (trigStart) begin
      state_nxt = sbcp_pkg::ST_WAIT;
    end else if (!cfgResetN || abortNow) begin
      state_nxt = sbcp_pkg::ST_IDLE;
    end else begin
      case (state_r)
        sbcp_pkg::ST_IDLE: state_nxt = sbcp_pkg::ST_IDLE;
        sbcp_pkg::ST_WAIT: begin
          if (waitCnt_r == 12'(sbcp_pkg::RESET_TO_DATA_DELAY_CYCLES - 1))
            state_nxt = modeActive_r ? sbcp_pkg::ST_WAKE : sbcp_pkg::ST_PASV;
        end
        sbcp_pkg::ST_WAKE: begin
          if (riseEdge && isLast(bitCnt_r, sbcp_pkg::WAKE_BITS))
            state_nxt = sbcp_pkg::ST_GAP;
        end
        sbcp_pkg::ST_GAP: begin
          if (waitCnt_r == 12'(sbcp_pkg::WAKE_GAP_CYCLES - 1))
            state_nxt = sbcp_pkg::ST_CMD;
        end
        sbcp_pkg::ST_CMD: begin
          if (riseEdge && isLast(bitCnt_r, sbcp_pkg::CMD_BITS))
            state_nxt = sbcp_pkg::ST_ADDR;
        end
        sbcp_pkg::ST_ADDR: begin
          if (riseEdge && isLast(bitCnt_r, sbcp_pkg::ADDR_BITS))
            state_nxt = sbcp_pkg::ST_DUMMY;
        end
        sbcp_pkg::ST_DUMMY: begin
          if (riseEdge && isLast(bitCnt_r, DUMMY_BITS))
            state_nxt = sbcp_pkg::ST_STREAM;
        end
        sbcp_pkg::ST_STREAM: begin
          if (bitstreamDone)
            state_nxt = sbcp_pkg::ST_DONE;
        end
        sbcp_pkg::ST_PASV: begin
          if (bitstreamDone)
            state_nxt = sbcp_pkg::ST_TAIL;
        end
        sbcp_pkg::ST_TAIL: begin
          if (tailCnt_r == 7'(sbcp_pkg::TAIL_CLOCKS))
            state_nxt = sbcp_pkg::ST_DONE;
        end
        sbcp_pkg::ST_DONE: state_nxt = sbcp_pkg::ST_DONE;
        default:           state_nxt = sbcp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset)
      state_r <= sbcp_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // wait timer for the start delay and the post-wake gap
  always_ff @(posedge core_clk) begin
    if (reset || state_nxt != state_r)
      waitCnt_r <= 12'h000;
    else if (state_r == sbcp_pkg::ST_WAIT || state_r == sbcp_pkg::ST_GAP)
      waitCnt_r <= waitCnt_r + 12'h001;
  end

  always_ff @(posedge core_clk) begin
    if (reset || state_nxt != state_r) begin
      bitCnt_r  <= 5'h00;
      tailCnt_r <= 7'h00;
    end else if (sampleEdge) begin
      bitCnt_r  <= bitCnt_r + 5'h01;
      if (state_r == sbcp_pkg::ST_TAIL && tailCnt_r != 7'(sbcp_pkg::TAIL_CLOCKS))
        tailCnt_r <= tailCnt_r + 7'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // active-mode shifter and pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txShift_r   <= 32'h0000_0000;
      flashCmdOut <= 1'b0;
    end else if (state_nxt != state_r) begin
      case (state_nxt)
        sbcp_pkg::ST_WAKE: txShift_r <= {sbcp_pkg::FLASH_CMD_WAKE, 24'h00_0000};
        sbcp_pkg::ST_CMD:  txShift_r <= {sbcp_pkg::FLASH_CMD_READ, 24'h00_0000};
        sbcp_pkg::ST_ADDR: txShift_r <= {START_ADDR, 8'h00};
        default:           txShift_r <= 32'h0000_0000;
      endcase
    end else if (fallEdge) begin
      flashCmdOut <= txShift_r[31];
      txShift_r   <= {txShift_r[30:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset)
      configSerialClockOut <= 1'b1;
    else if (isClocked(state_r) && edgeTick)
      configSerialClockOut <= !configSerialClockOut;
    else if (!isClocked(state_r))
      configSerialClockOut <= 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      configSerialClockOe <= 1'b0;
      flashSelectNOut     <= 1'b1;
      flashSelectNOe      <= 1'b0;
      flashCmdOe          <= 1'b0;
    end else begin
      configSerialClockOe <= isClocked(state_nxt) || state_nxt == sbcp_pkg::ST_GAP;
      flashSelectNOut     <= !isClocked(state_nxt);
      flashSelectNOe      <= isClocked(state_nxt) || state_nxt == sbcp_pkg::ST_GAP;
      flashCmdOe          <= isClocked(state_nxt) || state_nxt == sbcp_pkg::ST_GAP;
    end
  end

  // ---------------------------------------------------------------------------
  // byte assembly and status
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxShift_r    <= 8'h00;
      cfgByte      <= 8'h00;
      cfgByteValid <= 1'b0;
    end else begin
      cfgByteValid <= 1'b0;
      if (sampleEdge && (state_r == sbcp_pkg::ST_STREAM || state_r == sbcp_pkg::ST_PASV)) begin
        rxShift_r <= {rxShift_r[6:0], configDataIn};
        if (bitCnt_r[2:0] == 3'h7) begin
          cfgByte      <= {rxShift_r[6:0], configDataIn};
          cfgByteValid <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfgBusy  <= 1'b0;
      cfgDone  <= 1'b0;
      cfgAbort <= 1'b0;
    end else begin
      cfgBusy  <= state_nxt != sbcp_pkg::ST_IDLE && state_nxt != sbcp_pkg::ST_DONE;
      cfgDone  <= state_nxt == sbcp_pkg::ST_DONE;
      cfgAbort <= abortNow;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence enterAddr;
    (state_r == sbcp_pkg::ST_ADDR) && ($past(state_r) != sbcp_pkg::ST_ADDR);
  endsequence

  sequence enterStream;
    (state_r == sbcp_pkg::ST_STREAM) && ($past(state_r) != sbcp_pkg::ST_STREAM);
  endsequence

  AST_RESET_TO_DATA_DELAY_WAIT: assert property (
    ($past(state_r) == sbcp_pkg::ST_WAIT) &&
    (state_r == sbcp_pkg::ST_WAKE || state_r == sbcp_pkg::ST_PASV)
    |-> $past(waitCnt_r) == 12'(sbcp_pkg::RESET_TO_DATA_DELAY_CYCLES - 1))
    else $error("configuration left start delay early");

  AST_NO_DATA_IN_WAIT: assert property (
    state_r == sbcp_pkg::ST_WAIT |=> !cfgByteValid)
    else $error("byte delivered during start delay");

  AST_INT_CLK: assert property (
    isClocked(state_r) && !extSrc_r && $changed(configSerialClockOut) |-> $past(divTick))
    else $error("internal serial clock toggled without divider tick");

  AST_EXT_CLK: assert property (
    isClocked(state_r) && extSrc_r && $changed(configSerialClockOut) |-> $past(extEdge))
    else $error("serial clock toggled without external edge");

  AST_PASV_SAMPLE: assert property (
    state_r == sbcp_pkg::ST_PASV && state_nxt == state_r && pasvRise
    |=> bitCnt_r == $past(bitCnt_r) + 5'h01)
    else $error("passive rising edge not sampled");

  AST_MODE3_IDLE: assert property (
    state_r == sbcp_pkg::ST_PASV && !configSerialClockIn && state_nxt == state_r
    |=> bitCnt_r == $past(bitCnt_r))
    else $error("sample taken without rising clock edge");

  AST_TAIL_COUNT: assert property (
    state_r == sbcp_pkg::ST_TAIL ##1 state_r == sbcp_pkg::ST_DONE
    |-> $past(tailCnt_r) == 7'(sbcp_pkg::TAIL_CLOCKS))
    else $error("done reached before trailing clocks");

  AST_TRIG_WIDTH: assert property (
    state_r != sbcp_pkg::ST_WAIT ##1 state_r == sbcp_pkg::ST_WAIT
    |-> $past(trigLowCnt_r) == 6'(sbcp_pkg::TRIG_LOW_CYCLES))
    else $error("start accepted after short trigger pulse");

  AST_DESELECT: assert property (
    cfgResetN && !trigStart && !deviceSelect && state_r != sbcp_pkg::ST_DONE
    |=> state_r == sbcp_pkg::ST_IDLE && !cfgBusy)
    else $error("unselected device kept configuring");

  AST_CMD_ORDER: assert property (
    enterAddr |-> $past(state_r) == sbcp_pkg::ST_CMD && $past(flashCmdOe))
    else $error("address phase not preceded by read command");

  AST_DUMMY_ORDER: assert property (
    enterStream |-> $past(state_r) == sbcp_pkg::ST_DUMMY)
    else $error("stream started without dummy phase");

  AST_PIN_DIR: assert property (
    (state_r == sbcp_pkg::ST_PASV |-> !configSerialClockOe && !flashSelectNOe) and
    (isClocked(state_r) |-> configSerialClockOe && !flashSelectNOut))
    else $error("pin direction wrong for mode");

endmodule // sbcp_config_port

// ===== sbcp_pkg.sv
package sbcp_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int  CLK_MHZ            = 100;
  localparam int  RESET_TO_DATA_DELAY_US           = 32;
  localparam int  RESET_TO_DATA_DELAY_CYCLES       = RESET_TO_DATA_DELAY_US * CLK_MHZ;
  localparam real TRIG_LOW_US        = 0.32;
  localparam int  TRIG_LOW_CYCLES    = int'($ceil(TRIG_LOW_US * CLK_MHZ));
  localparam int  EXT_CLK_MAX_MHZ    = 100;
  localparam int  TAIL_CLOCKS        = 100;
  localparam int  WAKE_GAP_CYCLES    = 4;

  // ---------------------------------------------------------------------------
  // serial phase lengths in bits
  // ---------------------------------------------------------------------------
  localparam int  WAKE_BITS          = 8;
  localparam int  CMD_BITS           = 8;
  localparam int  ADDR_BITS          = 24;

  // ---------------------------------------------------------------------------
  // flash commands
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FLASH_CMD_WAKE = 8'hAB;
  localparam logic [7:0] FLASH_CMD_READ = 8'h03;

  // ---------------------------------------------------------------------------
  // internal clock ratio codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CFG_CLK_RATIO_FULL    = 2'h0;
  localparam logic [1:0] CFG_CLK_RATIO_HALF    = 2'h1;
  localparam logic [1:0] CFG_CLK_RATIO_QUARTER = 2'h2;
  localparam logic [1:0] CFG_CLK_RATIO_EIGHTH  = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_WAIT   = 4'h1,
    ST_WAKE   = 4'h2,
    ST_GAP    = 4'h3,
    ST_CMD    = 4'h4,
    ST_ADDR   = 4'h5,
    ST_DUMMY  = 4'h6,
    ST_STREAM = 4'h7,
    ST_PASV   = 4'h8,
    ST_TAIL   = 4'h9,
    ST_DONE   = 4'hA
  } sbcp_state_t;

endpackage

// ===== sbcp_clk_div.sv
`timescale 1ns/1ps
module sbcp_clk_div (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [1:0] ratioSel,
  output logic            tick
);

  logic [2:0] count_r;

  // half period of the serial clock, in core cycles minus one
  function automatic logic [2:0] halfLimit(input logic [1:0] sel);
    case (sel)
      sbcp_pkg::CFG_CLK_RATIO_FULL:    halfLimit = 3'h0;
      sbcp_pkg::CFG_CLK_RATIO_HALF:    halfLimit = 3'h1;
      sbcp_pkg::CFG_CLK_RATIO_QUARTER: halfLimit = 3'h3;
      default:                         halfLimit = 3'h7;
    endcase
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset || !run) begin
      count_r <= 3'h0;
      tick    <= 1'b0;
    end else if (count_r == halfLimit(ratioSel)) begin
      count_r <= 3'h0;
      tick    <= 1'b1;
    end else begin
      count_r <= count_r + 3'h1;
      tick    <= 1'b0;
    end
  end

endmodule // sbcp_clk_div

// ===== sbcp_flash_model.sv
`timescale 1ns/1ps
module sbcp_flash_model #(
  parameter int DUMMY_BITS = 8
) (
  input  wire logic        sck,
  input  wire logic        selN,
  input  wire logic        mosi,
  output logic             miso,
  output logic [7:0]       wakeSeen,
  output logic [31:0]      hdrSeen
);
  int         bitCnt;
  int         d;
  logic       inFrame;
  logic [7:0] b;
  initial begin
    inFrame  = 1'b0;
    miso     = 1'b0;
    wakeSeen = 8'h00;
    hdrSeen  = 32'h0000_0000;
    bitCnt   = 0;
  end
  // -------------------------------------------------------------------------
  // frame capture
  // -------------------------------------------------------------------------
  always @(negedge selN) begin
    bitCnt  = 0;
    inFrame = 1'b1;
  end
  always @(posedge sck) begin
    if (inFrame) begin
      if (bitCnt < 32) hdrSeen = {hdrSeen[30:0], mosi};
      bitCnt = bitCnt + 1;
    end
  end
  // -------------------------------------------------------------------------
  // read data, launched after the falling edge
  // -------------------------------------------------------------------------
  always @(negedge sck) begin
    d = bitCnt - 32 - DUMMY_BITS;
    if (selN === 1'b0 && d >= 0) begin
      b    = 8'h3C + 8'(d / 8) * 8'h11;
      miso = b[7 - d % 8];
    end else begin
      miso = ~miso;
    end
  end
  // released line shows no stale bit
  // select may rise with the last clock rise: close the frame just after
  always @(posedge selN) begin
    #1;
    inFrame = 1'b0;
    if (bitCnt == 8) wakeSeen = hdrSeen[7:0];
    miso = ~miso;
  end
endmodule // sbcp_flash_model

// ===== sbcp_config_port_tb.sv
`timescale 1ns/1ps
module sbcp_config_port_tb;
  localparam logic [23:0] START_ADDR = 24'h12_3456;
  localparam int          DUMMY_BITS = 8;
  // -------------------------------------------------------------------------
  // signals
  // -------------------------------------------------------------------------
  logic        core_clk;
  logic        reset;
  logic        cfgResetN;
  logic        deviceSelect;
  logic        activeModeSel;
  logic [1:0]  clkRatioSel;
  logic        useExtClock;
  logic        externalCfgClockPin;
  logic        hostSck;
  logic        hostSelN;
  logic        hostData;
  logic        bitstreamDone;
  logic        extEn;
  logic [1:0]  extCnt;
  logic        configSerialClockOut;
  logic        configSerialClockOe;
  logic        flashSelectNOut;
  logic        flashSelectNOe;
  logic        flashCmdOut;
  logic        flashCmdOe;
  logic [7:0]  cfgByte;
  logic        cfgByteValid;
  logic        cfgBusy;
  logic        cfgDone;
  logic        cfgAbort;
  logic        flashMiso;
  logic [7:0]  wakeSeen;
  logic [31:0] hdrSeen;
  logic [7:0]  got[$];
  int          mismatches;
  int          comparisons;
  wire         sckWire  = configSerialClockOe ? configSerialClockOut : hostSck;
  wire         selWire  = flashSelectNOe ? flashSelectNOut : hostSelN;
  wire         dataWire = flashCmdOe ? flashMiso : hostData;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // -------------------------------------------------------------------------
  // design, flash and monitors
  // -------------------------------------------------------------------------
  sbcp_config_port #(.START_ADDR(START_ADDR), .DUMMY_BITS(DUMMY_BITS)) u_sbcp_config_port (
    .core_clk(core_clk), .reset(reset), .cfgResetN(cfgResetN), .deviceSelect(deviceSelect),
    .activeModeSel(activeModeSel), .clkRatioSel(clkRatioSel), .useExtClock(useExtClock),
    .externalCfgClockPin(externalCfgClockPin), .configSerialClockIn(sckWire),
    .configSerialClockOut(configSerialClockOut), .configSerialClockOe(configSerialClockOe),
    .flashSelectNIn(selWire), .flashSelectNOut(flashSelectNOut),
    .flashSelectNOe(flashSelectNOe), .configDataIn(dataWire), .flashCmdOut(flashCmdOut),
    .flashCmdOe(flashCmdOe), .bitstreamDone(bitstreamDone), .cfgByte(cfgByte),
    .cfgByteValid(cfgByteValid), .cfgBusy(cfgBusy), .cfgDone(cfgDone), .cfgAbort(cfgAbort));
  // single target on the bus
  sbcp_flash_model #(.DUMMY_BITS(DUMMY_BITS)) u_sbcp_flash_model (.sck(sckWire),
    .selN(selWire), .mosi(flashCmdOut), .miso(flashMiso), .wakeSeen(wakeSeen),
    .hdrSeen(hdrSeen));
  always @(posedge core_clk) if (cfgByteValid === 1'b1) got.push_back(cfgByte);
  always @(posedge core_clk) begin
    if (extEn) begin
      extCnt <= extCnt + 2'h1;
      if (extCnt == 2'h3) externalCfgClockPin <= ~externalCfgClockPin;
    end
  end
  // -------------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------------
  task automatic test_done;
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      mismatches++;
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = cfgBusy;
      1: pick = flashSelectNOe;
      2: pick = configSerialClockOut;
      3: pick = cfgAbort;
      4: pick = cfgDone;
      default: pick = (got.size() >= 3);
    endcase
  endfunction
  task automatic waitOn(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (pick(k) !== v) begin
      $display("MISMATCH wait %0d expected %0b seen %0b", k, v, pick(k));
      mismatches++;
      test_done;
    end
  endtask
  task automatic trigger(input int low, input logic mode, input logic [1:0] ratio,
                         input logic ext);
    int oeSeen;
    oeSeen = 0;
    got.delete();
    activeModeSel <= mode;
    clkRatioSel   <= ratio;
    useExtClock   <= ext;
    cfgResetN     <= 1'b0;
    repeat (low) @(posedge core_clk);
    cfgResetN <= 1'b1;
    if (low >= 32) begin
      repeat (3) @(posedge core_clk);
      check("busy", cfgBusy, 1);
      // returns on the last edge of the start delay
      repeat (sbcp_pkg::RESET_TO_DATA_DELAY_CYCLES - 3) begin
        @(posedge core_clk);
        if (flashSelectNOe !== 1'b0 || cfgByteValid !== 1'b0) oeSeen++;
      end
      check("early", oeSeen, 0);
    end
  endtask
  task automatic pulse(input logic b);
    hostSck  <= 1'b0;
    hostData <= b;
    repeat (2) @(posedge core_clk);
    hostSck <= 1'b1; // idles high, sampled rising
    repeat (2) @(posedge core_clk);
  endtask
  task automatic sendNib(input logic [3:0] v);
    for (int i = 3; i >= 0; i--) pulse(v[i]);
  endtask
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic activeRun(input logic [1:0] ratio, input logic ext, input int half,
                           input logic abortIt);
    int n;
    n = 0;
    trigger(32, 1'b1, ratio, ext);
    waitOn(1, 1'b1, 100);
    check("oeClk", configSerialClockOe, 1);
    check("oeCmd", flashCmdOe, 1);
    waitOn(2, 1'b0, 40);
    while (configSerialClockOut !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    check("half", n, half);
    waitOn(5, 1'b1, 3000);
    check("wake", wakeSeen, sbcp_pkg::FLASH_CMD_WAKE);
    check("hdr", hdrSeen, {sbcp_pkg::FLASH_CMD_READ, START_ADDR});
    for (int k = 0; k < 3; k++) check("data", got[k], 8'h3C + 8'(k) * 8'h11);
    if (abortIt) begin
      deviceSelect <= 1'b0;
      waitOn(3, 1'b1, 6);
      repeat (2) @(posedge core_clk);
      check("abortOe", flashSelectNOe, 0);
      check("abortBusy", cfgBusy, 0);
      deviceSelect <= 1'b1;
    end else begin
      bitstreamDone <= 1'b1;
      waitOn(4, 1'b1, 500);
      bitstreamDone <= 1'b0;
    end
  endtask
  task automatic passiveRun;
    trigger(32, 1'b0, 2'h0, 1'b0);
    hostSelN <= 1'b0;
    sendNib(4'hC);
    sendNib(4'h3);
    sendNib(4'h5);
    repeat (20) @(posedge core_clk); // clock held high while no data
    sendNib(4'hA); // continue where stopped
    repeat (4) @(posedge core_clk);
    check("pCount", got.size(), 2);
    check("pByte0", got[0], 8'hC3);
    check("pByte1", got[1], 8'h5A);
    check("pOe", configSerialClockOe, 0);
    bitstreamDone <= 1'b1;
    repeat (2) @(posedge core_clk);
    repeat (99) pulse(1'b0);
    check("tail99", cfgDone, 0);
    pulse(1'b0);
    waitOn(4, 1'b1, 6);
    bitstreamDone <= 1'b0;
    hostSelN      <= 1'b1;
  endtask
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    mismatches = 0;
    comparisons = 0;
    reset = 1'b1;
    cfgResetN = 1'b1;
    deviceSelect = 1'b1;
    activeModeSel = 1'b0;
    clkRatioSel = 2'h0;
    useExtClock = 1'b0;
    externalCfgClockPin = 1'b0;
    extEn = 1'b0; // external pin idle with internal source
    extCnt = 2'h0;
    hostSck = 1'b1;
    hostSelN = 1'b1;
    hostData = 1'b0;
    bitstreamDone = 1'b0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check("rstClk", configSerialClockOut, 1);
    check("rstSel", flashSelectNOut, 1);
    check("rstOe", configSerialClockOe, 0);
    trigger(31, 1'b1, 2'h0, 1'b0);
    repeat (10) @(posedge core_clk);
    check("shortTrig", cfgBusy, 0);
    activeRun(sbcp_pkg::CFG_CLK_RATIO_FULL, 1'b0, 1, 1'b0);
    activeRun(sbcp_pkg::CFG_CLK_RATIO_HALF, 1'b0, 2, 1'b0);
    activeRun(sbcp_pkg::CFG_CLK_RATIO_QUARTER, 1'b0, 4, 1'b0);
    activeRun(sbcp_pkg::CFG_CLK_RATIO_EIGHTH, 1'b0, 8, 1'b0);
    extEn <= 1'b1;
    activeRun(2'h0, 1'b1, 4, 1'b1);
    extEn <= 1'b0;
    passiveRun;
    test_done;
  end
endmodule // sbcp_config_port_tb
